/* File: rtl/mmd_pkg.sv */
/*
  Constants, carrier types and helpers for the memory map and bank decoder.
  Assumes the core issues one request per port at a time, all on one clock.
*/
package mmd_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] MMD_SFR_BASE       = 8'h80;
  localparam logic [7:0] MMD_ROM_BANK_ADDR  = 8'hAB;
  localparam logic [7:0] MMD_PWR_MGMT_ADDR  = 8'hC4;
  localparam logic [3:0] MMD_ROM_BANK_RST   = 4'h7;
  localparam int         MMD_BANK_EN_BIT    = 3;
  localparam int         MMD_PIN_SEL_LSB    = 0;
  localparam int         MMD_PIN_SEL_W      = 3;
  localparam int         MMD_XRAM_EN_BIT    = 0;
  localparam logic       MMD_XRAM_EN_RST    = 1'b0;
  localparam logic [7:0] MMD_UNIMPL_READ    = 8'hFF;
  localparam logic [3:0] MMD_ROM_BANK_UNUSED = 4'hF;
  localparam logic [6:0] MMD_PWR_MGMT_UNUSED = 7'h7F;

  // ----------------------------------------------------------------
  // Memory sizes
  // ----------------------------------------------------------------
  localparam int          MMD_APP_BANK_BYTES = 65536;
  localparam int          MMD_LOADER_BYTES   = 4096;
  localparam int          MMD_XRAM_BYTES     = 1024;
  localparam int          MMD_SCRATCH_BYTES  = 256;
  localparam logic [15:0] MMD_XRAM_TOP       = 16'h03FF;

  // ----------------------------------------------------------------
  // Carriers and states
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } mmd_xreq_t;

  typedef struct packed {
    logic       wr;
    logic       indirect;
    logic       bit_op;
    logic [2:0] bit_idx;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mmd_ireq_t;

  typedef enum logic [1:0] {
    MMD_XS_IDLE = 2'b00,
    MMD_XS_INT  = 2'b01,
    MMD_XS_EXT  = 2'b10
  } mmd_xstate_t;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic mmd_bit_addressable(input logic [7:0] a);
    return a[2:0] == 3'h0;
  endfunction : mmd_bit_addressable

  function automatic logic mmd_hits_xram(input logic [15:0] a, input logic en);
    return en && (a <= MMD_XRAM_TOP);
  endfunction : mmd_hits_xram

endpackage : mmd_pkg

/* File: rtl/mmd_xram.sv */
/*
  On-chip data SRAM reached by external data moves.
  Assumes one access per enabled cycle; read data appears one cycle later.
*/
`timescale 1ns/100ps
module mmd_xram #(
  parameter int DEPTH = 1024,
  parameter int AW    = 10
) (
  input  wire logic          clk,
  input  wire logic          en,
  input  wire logic          wr,
  input  wire logic [AW-1:0] addr,
  input  wire logic [7:0]    wdata,
  output logic      [7:0]    rdata_q
);

  logic [7:0] mem_q [DEPTH];

  // ----------------------------------------------------------------
  // Storage, no reset: contents are undefined until written
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (en && wr) begin
      mem_q[addr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (en) begin
      rdata_q <= mem_q[addr];
    end
  end

endmodule : mmd_xram

/* File: rtl/mmd_decoder.sv */
/*
  Memory map and bank decoder: program fetch banking, external data routing,
  scratchpad and special register decode.
  Assumes the core holds a request for one cycle and waits for its answer.
*/
// How it works
// - Code space spans two 64KB application banks via a seventeenth address bit.
// - After reset, fetches use application bank 0 until banking is enabled.
// - Bank enable bit 3 drives a chosen port-1 pin as address bit 16.
// - Three-bit pin select picks port-1 pin 0..7; pin 7 by default.
// - Instruction fetches and code table reads both decode to application flash.
// - A separate 4KB loader flash is selected when the loader is running.
// - External data moves address up to 64KB of data memory.
// - With on-chip RAM enabled, 0000h..03FFh goes to the internal 1KB SRAM.
// - External data moves above 03FFh always go to the external bus.
// - With on-chip RAM disabled (reset), every external data move goes external.
// - 256 bytes of scratchpad RAM: 00h..7Fh reachable directly, all of it indirectly.
// - Special registers live at 80h..FFh and answer direct accesses only.
// - Only register addresses ending in 0 or 8 allow single-bit access.
// - Unimplemented registers and bits read as ones.
// - Bank control at ABh: bits 7..4 unused, bit 3 enable, bits 2..0 pin.
`timescale 1ns/100ps
module mmd_decoder
#(
  parameter int XRAM_BYTES = mmd_pkg::MMD_XRAM_BYTES
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              fetch_req,
  input  wire logic [15:0]       code_addr,
  input  wire logic              run_loader,
  input  wire logic [7:0]        p1_latch,
  output logic                   fetch_valid_q,
  output logic [16:0]            flash_addr_q,
  output logic                   loader_sel_q,
  output logic [7:0]             p1_hi_addr_out,
  output logic [7:0]             p1_hi_addr_oe,
  input  wire logic              int_req,
  input  wire mmd_pkg::mmd_ireq_t int_cmd,
  output logic                   int_ack_q,
  output logic [7:0]             int_rdata_q,
  input  wire logic              xdm_req,
  input  wire mmd_pkg::mmd_xreq_t xdm_cmd,
  output logic                   xdm_ready,
  output logic                   xdm_done_q,
  output logic [7:0]             xdm_rdata_q,
  output logic                   ext_req_q,
  output mmd_pkg::mmd_xreq_t     ext_cmd_q,
  input  wire logic              ext_done,
  input  wire logic [7:0]        ext_rdata
);

  import mmd_pkg::*;

  localparam int XAW = $clog2(XRAM_BYTES);

  logic [3:0]  rom_bank_control_q;
  logic        onchip_xram_enable_q;
  logic        bank_en_f_q;
  logic [2:0]  pin_sel_f_q;
  logic [7:0]  scratch_q [MMD_SCRATCH_BYTES];
  mmd_xstate_t xstate_q;
  logic        direct_sfr;
  logic        sfr_wr;
  logic        xram_go;
  logic [7:0]  xram_rdata;
  logic        a16;

  // ----------------------------------------------------------------
  // Special register decode
  // ----------------------------------------------------------------
  assign direct_sfr = !int_cmd.indirect && (int_cmd.addr >= MMD_SFR_BASE);
  // Neither mapped register is bit-addressable, so bit writes never land
  assign sfr_wr = int_req && direct_sfr && int_cmd.wr && !int_cmd.bit_op;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rom_bank_control_q <= MMD_ROM_BANK_RST;
    end else if (sfr_wr && int_cmd.addr == MMD_ROM_BANK_ADDR) begin
      rom_bank_control_q <= int_cmd.wdata[3:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      onchip_xram_enable_q <= MMD_XRAM_EN_RST;
    end else if (sfr_wr && int_cmd.addr == MMD_PWR_MGMT_ADDR) begin
      onchip_xram_enable_q <= int_cmd.wdata[MMD_XRAM_EN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Scratchpad and read path
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (int_req && int_cmd.wr && !direct_sfr && !int_cmd.bit_op) begin
      scratch_q[int_cmd.addr] <= int_cmd.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      int_ack_q   <= 1'b0;
      int_rdata_q <= MMD_UNIMPL_READ;
    end else begin
      int_ack_q <= int_req;
      if (int_req && !int_cmd.wr) begin
        if (!direct_sfr) begin
          int_rdata_q <= scratch_q[int_cmd.addr];
        end else if (int_cmd.bit_op && !mmd_bit_addressable(int_cmd.addr)) begin
          int_rdata_q <= MMD_UNIMPL_READ;
        end else if (int_cmd.addr == MMD_ROM_BANK_ADDR) begin
          int_rdata_q <= {MMD_ROM_BANK_UNUSED, rom_bank_control_q};
        end else if (int_cmd.addr == MMD_PWR_MGMT_ADDR) begin
          int_rdata_q <= {MMD_PWR_MGMT_UNUSED, onchip_xram_enable_q};
        end else begin
          int_rdata_q <= MMD_UNIMPL_READ;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Program fetch banking
  // ----------------------------------------------------------------
  // Settings are sampled per fetch so a write mid-fetch cannot tear it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bank_en_f_q <= 1'b0;
      pin_sel_f_q <= MMD_ROM_BANK_RST[2:0];
    end else if (fetch_req) begin
      bank_en_f_q <= rom_bank_control_q[MMD_BANK_EN_BIT];
      pin_sel_f_q <= rom_bank_control_q[MMD_PIN_SEL_LSB +: MMD_PIN_SEL_W];
    end
  end

  assign a16 = rom_bank_control_q[MMD_BANK_EN_BIT]
             && p1_latch[rom_bank_control_q[2:0]];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fetch_valid_q <= 1'b0;
      flash_addr_q  <= 17'h00000;
      loader_sel_q  <= 1'b0;
    end else begin
      fetch_valid_q <= fetch_req;
      if (fetch_req) begin
        loader_sel_q <= run_loader;
        if (run_loader) begin
          flash_addr_q <= {5'h00, code_addr[11:0]};
        end else begin
          flash_addr_q <= {a16, code_addr};
        end
      end
    end
  end

  assign p1_hi_addr_out = {8{flash_addr_q[16]}};
  assign p1_hi_addr_oe  = bank_en_f_q ? (8'h01 << pin_sel_f_q) : 8'h00;

  // ----------------------------------------------------------------
  // External data move routing
  // ----------------------------------------------------------------
  assign xdm_ready = (xstate_q == MMD_XS_IDLE);
  assign xram_go   = xdm_req && xdm_ready
                   && mmd_hits_xram(xdm_cmd.addr, onchip_xram_enable_q);

  mmd_xram #(.DEPTH(XRAM_BYTES), .AW(XAW)) u_xram (
    .clk     (clk),
    .en      (xram_go),
    .wr      (xdm_cmd.wr),
    .addr    (xdm_cmd.addr[XAW-1:0]),
    .wdata   (xdm_cmd.wdata),
    .rdata_q (xram_rdata)
  );

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      xstate_q    <= MMD_XS_IDLE;
      xdm_done_q  <= 1'b0;
      xdm_rdata_q <= 8'h00;
      ext_req_q   <= 1'b0;
      ext_cmd_q   <= '0;
    end else begin
      xdm_done_q <= 1'b0;
      ext_req_q  <= 1'b0;
      case (xstate_q)
        MMD_XS_IDLE: begin
          if (xram_go) begin
            xstate_q <= MMD_XS_INT;
          end else if (xdm_req) begin
            xstate_q  <= MMD_XS_EXT;
            ext_req_q <= 1'b1;
            ext_cmd_q <= xdm_cmd;
          end
        end
        MMD_XS_INT: begin
          xdm_rdata_q <= xram_rdata;
          xdm_done_q  <= 1'b1;
          xstate_q    <= MMD_XS_IDLE;
        end
        MMD_XS_EXT: begin
          if (ext_done) begin
            xdm_rdata_q <= ext_rdata;
            xdm_done_q  <= 1'b1;
            xstate_q    <= MMD_XS_IDLE;
          end
        end
        default: xstate_q <= MMD_XS_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_rst_bank;
    @(posedge clk) $fell(sys_rst) |-> rom_bank_control_q == MMD_ROM_BANK_RST && !bank_en_f_q;
  endproperty
  a_rst_bank: assert property (p_rst_bank) else $error("bank control reset value wrong");

  property p_bank0;
    @(posedge clk) disable iff (sys_rst)
      fetch_req && !run_loader && !rom_bank_control_q[MMD_BANK_EN_BIT] |=> !flash_addr_q[16];
  endproperty
  a_bank0: assert property (p_bank0) else $error("bank 1 used while banking off");

  property p_pin;
    @(posedge clk) disable iff (sys_rst)
      fetch_req && rom_bank_control_q[MMD_BANK_EN_BIT]
      |=> p1_hi_addr_oe == (8'h01 << $past(rom_bank_control_q[2:0]));
  endproperty
  a_pin: assert property (p_pin) else $error("wrong port pin for high address");

  property p_fetch_hold;
    @(posedge clk) disable iff (sys_rst)
      !fetch_req |=> $stable(bank_en_f_q) && $stable(pin_sel_f_q);
  endproperty
  a_fetch_hold: assert property (p_fetch_hold) else $error("bank changed mid fetch");

  property p_int_route;
    @(posedge clk) disable iff (sys_rst)
      xdm_req && xdm_ready && onchip_xram_enable_q && xdm_cmd.addr <= MMD_XRAM_TOP
      |=> !ext_req_q ##1 xdm_done_q;
  endproperty
  a_int_route: assert property (p_int_route) else $error("internal SRAM not used");

  property p_ext_route;
    @(posedge clk) disable iff (sys_rst)
      xdm_req && xdm_ready && xdm_cmd.addr > MMD_XRAM_TOP
      |=> ext_req_q && ext_cmd_q.addr == $past(xdm_cmd.addr);
  endproperty
  a_ext_route: assert property (p_ext_route) else $error("high address not external");

  property p_ext_off;
    @(posedge clk) disable iff (sys_rst)
      xdm_req && xdm_ready && !onchip_xram_enable_q |=> ext_req_q;
  endproperty
  a_ext_off: assert property (p_ext_off) else $error("access not external while disabled");

  property p_indirect;
    @(posedge clk) disable iff (sys_rst)
      int_req && int_cmd.indirect && int_cmd.wr |=> $stable(rom_bank_control_q);
  endproperty
  a_indirect: assert property (p_indirect) else $error("indirect write hit register");

  property p_unimpl;
    @(posedge clk) disable iff (sys_rst)
      int_req && !int_cmd.wr && direct_sfr && int_cmd.addr != MMD_ROM_BANK_ADDR
      && int_cmd.addr != MMD_PWR_MGMT_ADDR |=> int_rdata_q == MMD_UNIMPL_READ;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented read not ones");

  property p_rbc_read;
    @(posedge clk) disable iff (sys_rst)
      int_req && !int_cmd.wr && direct_sfr && !int_cmd.bit_op
      && int_cmd.addr == MMD_ROM_BANK_ADDR |=> int_rdata_q == {4'hF, rom_bank_control_q};
  endproperty
  a_rbc_read: assert property (p_rbc_read) else $error("bank control readback wrong");

  c_int:  cover property (@(posedge clk) xram_go ##2 xdm_done_q);
  c_ext:  cover property (@(posedge clk) ext_req_q ##[1:20] xdm_done_q);
  c_bank: cover property (@(posedge clk) fetch_valid_q && flash_addr_q[16]);
  c_wr:   cover property (@(posedge clk) sfr_wr && int_cmd.addr == MMD_ROM_BANK_ADDR);

endmodule : mmd_decoder

/* File: tb/mmd_ext_mem.sv */
/*
  External data memory model on the far side of the multiplexed bus.
  Assumes one bus cycle at a time, each opened by a one-cycle request pulse.
*/
`timescale 1ns/100ps
module mmd_ext_mem (
  input  wire logic              clk,
  input  wire logic              ext_req,
  input  wire mmd_pkg::mmd_xreq_t ext_cmd,
  input  wire logic              slow,
  output logic                   ext_done,
  output logic [7:0]             ext_rdata
);
  import mmd_pkg::*;
  // ----------------------------------------------------------------
  // Bus responder
  // ----------------------------------------------------------------
  logic [7:0] mem [logic [15:0]];
  mmd_xreq_t  cmd;
  initial begin
    ext_done  = 1'b0;
    ext_rdata = 8'h00;
    forever begin
      @(posedge clk);
      if (ext_req) begin
        cmd = ext_cmd;
        repeat (slow ? 4 : 0) @(posedge clk);
        ext_done <= 1'b1;
        if (cmd.wr) mem[cmd.addr] = cmd.wdata;
        else ext_rdata <= mem.exists(cmd.addr) ? mem[cmd.addr] : 8'h5A;
        @(posedge clk);
        ext_done  <= 1'b0;
        // Released data lines show no stale byte
        ext_rdata <= ~ext_rdata;
      end
    end
  end
endmodule : mmd_ext_mem

/* File: tb/test_mmd_decoder.sv */
/*
  Self-checking bench for the memory map and bank decoder.
  Assumes the external memory model answers every bus cycle it sees.
*/
`timescale 1ns/100ps
module test_mmd_decoder;
  import mmd_pkg::*;
  // ----------------------------------------------------------------
  // Signals and expectation queues
  // ----------------------------------------------------------------
  logic        clk = 1'b0, sys_rst = 1'b1, fetch_req = 1'b0, run_loader = 1'b0;
  logic        int_req = 1'b0, xdm_req = 1'b0, slow = 1'b0, saw_ext = 1'b0;
  logic [15:0] code_addr = 16'h0000;
  logic [7:0]  p1_latch = 8'h00;
  mmd_ireq_t   int_cmd = '0;
  mmd_xreq_t   xdm_cmd = '0;
  logic        fetch_valid_q, loader_sel_q, int_ack_q, xdm_ready, xdm_done_q, ext_req_q;
  logic        ext_done;
  logic [16:0] flash_addr_q;
  logic [7:0]  p1_hi_addr_out, p1_hi_addr_oe, int_rdata_q, xdm_rdata_q, ext_rdata;
  mmd_xreq_t   ext_cmd_q;
  logic [25:0] fq[$];
  logic [8:0]  iq[$];
  logic [9:0]  xq[$];
  logic [3:0]  ctrl = 4'h7;
  logic        xen = 1'b0;
  logic [31:0] rnd = 32'h4;
  logic [7:0]  ua [4] = '{8'h80, 8'h90, 8'hD7, 8'hFF};
  logic [15:0] xa [4] = '{16'h0000, 16'h03FF, 16'h0400, 16'hFFFF};
  int          bad_count = 0, tests_run = 0, cyc = 0;

  always #5 clk = ~clk;

  mmd_decoder u_mmd_decoder (.clk(clk), .sys_rst(sys_rst), .fetch_req(fetch_req),
    .code_addr(code_addr), .run_loader(run_loader), .p1_latch(p1_latch),
    .fetch_valid_q(fetch_valid_q), .flash_addr_q(flash_addr_q), .loader_sel_q(loader_sel_q),
    .p1_hi_addr_out(p1_hi_addr_out), .p1_hi_addr_oe(p1_hi_addr_oe), .int_req(int_req),
    .int_cmd(int_cmd), .int_ack_q(int_ack_q), .int_rdata_q(int_rdata_q), .xdm_req(xdm_req),
    .xdm_cmd(xdm_cmd), .xdm_ready(xdm_ready), .xdm_done_q(xdm_done_q),
    .xdm_rdata_q(xdm_rdata_q), .ext_req_q(ext_req_q), .ext_cmd_q(ext_cmd_q),
    .ext_done(ext_done), .ext_rdata(ext_rdata));
  mmd_ext_mem u_mmd_ext_mem (.clk(clk), .ext_req(ext_req_q), .ext_cmd(ext_cmd_q),
    .slow(slow), .ext_done(ext_done), .ext_rdata(ext_rdata));

  // ----------------------------------------------------------------
  // Helpers, drivers and compares
  // ----------------------------------------------------------------
  function logic [31:0] xs();
    rnd = rnd ^ (rnd << 13);
    rnd = rnd ^ (rnd >> 17);
    rnd = rnd ^ (rnd << 5);
    return rnd;
  endfunction : xs

  task automatic cmp_fetch(input logic [33:0] e, input logic [33:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("Error fetch exp %h got %h", e, g);
    end
  endtask : cmp_fetch

  task automatic cmp_int(input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("Error int_rdata exp %h got %h", e, g);
    end
  endtask : cmp_int

  task automatic cmp_xdm(input logic [8:0] e, input logic [8:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("Error xdm route_data exp %h got %h", e, g);
    end
  endtask : cmp_xdm

  // Read data doubles as write data, so one argument serves both kinds
  task automatic int_op(input logic wr, ind, bop, input logic [7:0] a, d, input logic chk);
    int_req <= 1'b1;
    int_cmd <= {wr, ind, bop, 3'h0, a, d};
    iq.push_back({chk, d});
    if (wr && !ind && !bop && a == MMD_ROM_BANK_ADDR) ctrl <= d[3:0];
    if (wr && !ind && !bop && a == MMD_PWR_MGMT_ADDR) xen <= d[MMD_XRAM_EN_BIT];
    @(posedge clk);
  endtask : int_op

  task automatic fetch_op(input logic [15:0] a, input logic ldr, input logic [7:0] p1);
    logic a16;
    a16 = ctrl[3] & p1[ctrl[2:0]];
    fetch_req <= 1'b1;
    code_addr <= a;
    run_loader <= ldr;
    p1_latch <= p1;
    fq.push_back({ctrl[3] ? 8'h01 << ctrl[2:0] : 8'h00, ldr,
                  ldr ? {5'h00, a[11:0]} : {a16, a}});
    @(posedge clk);
  endtask : fetch_op

  task automatic idle();
    fetch_req <= 1'b0;
    int_req <= 1'b0;
    @(posedge clk);
  endtask : idle

  task automatic xdm_op(input logic wr, input logic [15:0] a, input logic [7:0] d);
    logic r;
    xdm_req <= 1'b1;
    xdm_cmd <= {wr, a, d};
    xq.push_back({wr, !(xen && a <= MMD_XRAM_TOP), d});
    r = 1'b0;
    while (!r) begin
      @(negedge clk);
      r = xdm_ready;
      @(posedge clk);
    end
    xdm_req <= 1'b0;
    @(posedge clk);
  endtask : xdm_op

  task automatic finish_test();
    // Notes still queued mean results that never showed up
    if (fq.size() + iq.size() + xq.size() != 0) bad_count++;
    $display("Checks run %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  // Results pop the oldest note; data move writes check only the route
  always @(posedge clk) begin : mon
    logic [25:0] f;
    logic [8:0]  i;
    logic [9:0]  x;
    cyc++;
    if (cyc > 3000) begin
      bad_count++;
      $display("Error timeout exp %0d got %0d", 3000, cyc);
      finish_test();
    end
    if (!sys_rst && ext_req_q) saw_ext = 1'b1;
    if (!sys_rst && fetch_valid_q) begin
      f = fq.pop_front();
      cmp_fetch({{8{f[16]}}, f}, {p1_hi_addr_out, p1_hi_addr_oe, loader_sel_q,
                flash_addr_q});
    end
    if (!sys_rst && int_ack_q) begin
      i = iq.pop_front();
      if (i[8]) cmp_int(i[7:0], int_rdata_q);
    end
    if (!sys_rst && xdm_done_q) begin
      x = xq.pop_front();
      cmp_xdm({x[8], x[9] ? 8'h00 : x[7:0]}, {saw_ext, x[9] ? 8'h00 : xdm_rdata_q});
      saw_ext = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] r;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    int_op(1'b0, 1'b0, 1'b0, MMD_ROM_BANK_ADDR, 8'hF7, 1'b1);
    int_op(1'b0, 1'b0, 1'b0, MMD_PWR_MGMT_ADDR, 8'hFE, 1'b1);
    for (int k = 0; k < 4; k++) int_op(1'b0, 1'b0, 1'b0, ua[k], MMD_UNIMPL_READ, 1'b1);
    // Drop the held request so no unnoted reads follow
    idle();
    fetch_op(16'h1234, 1'b0, 8'hFF);
    fetch_op(16'hF234, 1'b1, 8'hFF);
    idle();
    $display("reset values test done");
    int_op(1'b1, 1'b0, 1'b0, MMD_ROM_BANK_ADDR, 8'h0A, 1'b0);
    int_op(1'b0, 1'b0, 1'b0, MMD_ROM_BANK_ADDR, 8'hFA, 1'b1);
    int_op(1'b1, 1'b0, 1'b1, MMD_ROM_BANK_ADDR, 8'h05, 1'b0);
    int_op(1'b0, 1'b0, 1'b1, MMD_ROM_BANK_ADDR, 8'hFF, 1'b1);
    int_op(1'b1, 1'b1, 1'b0, MMD_ROM_BANK_ADDR, 8'h55, 1'b0);
    int_op(1'b0, 1'b0, 1'b0, MMD_ROM_BANK_ADDR, 8'hFA, 1'b1);
    int_op(1'b0, 1'b1, 1'b0, MMD_ROM_BANK_ADDR, 8'h55, 1'b1);
    int_op(1'b1, 1'b0, 1'b0, 8'h30, 8'hC3, 1'b0);
    int_op(1'b0, 1'b1, 1'b0, 8'h30, 8'hC3, 1'b1);
    for (int k = 0; k < 8; k++) begin
      r = xs();
      int_op(1'b1, 1'b0, 1'b0, {1'b0, r[6:0]}, r[15:8], 1'b0);
      int_op(1'b0, 1'b0, 1'b0, {1'b0, r[6:0]}, r[15:8], 1'b1);
    end
    idle();
    $display("register and scratchpad test done");
    for (int s = 0; s < 8; s++) begin
      r = xs();
      fork
        int_op(1'b1, 1'b0, 1'b0, MMD_ROM_BANK_ADDR, {5'h01, s[2:0]}, 1'b0);
        fetch_op(r[15:0], 1'b0, r[23:16]);
      join
      idle();
      fetch_op(r[31:16], 1'b0, r[7:0]);
    end
    idle();
    $display("bank select test done");
    xdm_op(1'b1, 16'h0010, 8'h11);
    xdm_op(1'b0, 16'h0010, 8'h11);
    int_op(1'b1, 1'b0, 1'b0, MMD_PWR_MGMT_ADDR, 8'h01, 1'b0);
    idle();
    xdm_op(1'b1, 16'h0010, 8'h22);
    xdm_op(1'b0, 16'h0010, 8'h22);
    for (int k = 0; k < 4; k++) begin
      slow <= k[0];
      xdm_op(1'b1, xa[k], 8'h3C ^ k[7:0]);
      xdm_op(1'b0, xa[k], 8'h3C ^ k[7:0]);
    end
    for (int k = 0; k < 4; k++) begin
      r = xs();
      xdm_op(1'b1, r[15:0], r[23:16]);
      xdm_op(1'b0, r[15:0], r[23:16]);
    end
    int_op(1'b1, 1'b0, 1'b0, MMD_PWR_MGMT_ADDR, 8'h00, 1'b0);
    idle();
    xdm_op(1'b0, 16'h0010, 8'h11);
    $display("data move test done");
    // A slow external read may still be in flight; wait for every result
    wait (fq.size() == 0 && iq.size() == 0 && xq.size() == 0);
    repeat (4) @(posedge clk);
    finish_test();
  end
endmodule : test_mmd_decoder
